/* File: spo_pkg.sv */
/*
 * Shared constants for the supply-enable output pin block: command code,
 * field positions, reset value and pin function codes.
 * Assumes a single 10 MHz core clock and a synchronous active-high reset.
 */
package spo_pkg;

    localparam int          SPO_PINS        = 12;
    localparam int          SPO_CHANNELS    = 16;
    localparam int          SPO_DELAY_W     = 16;

    localparam logic [7:0]  CMD_PIN_CFG     = 8'hD2;
    localparam logic [7:0]  PAGE_FAULT_TWO  = 8'h0A;
    localparam logic [7:0]  PAGE_SEQ_PIN    = 8'h0B;

    localparam int          MASK_LSB        = 16;
    localparam int          MASK_MSB        = 31;
    localparam int          DRIVE_TYPE_BIT  = 7;
    localparam int          POLARITY_BIT    = 6;
    localparam int          FUNC_MSB        = 2;
    localparam int          FUNC_LSB        = 0;

    localparam logic [31:0] CFG_RESET       = 32'h0000_0000;
    // Bits that store a value; all others read as zero
    localparam logic [31:0] CFG_RW_MASK     = 32'hFFFF_00C7;

    localparam logic [2:0]  FUNC_SUPPLY_EN  = 3'h0;
    localparam logic [2:0]  FUNC_FORCE_ON   = 3'h1;
    localparam logic [2:0]  FUNC_FORCE_OFF  = 3'h2;
    localparam logic [2:0]  FUNC_GOOD_AND   = 3'h3;
    localparam logic [2:0]  FUNC_ALARM_OR   = 3'h4;
    localparam logic [2:0]  FUNC_SPECIAL    = 3'h5;

endpackage

/* File: spo_filt_if.sv */
/*
 * Carrier between the pin logic and one on/off delay filter.
 * Assumes both ends share core_clk.
 */
interface spo_filt_if #(parameter int DW = 16);
    logic          raw;
    logic [DW-1:0] on_delay;
    logic [DW-1:0] off_delay;
    logic          filtered;

    modport ctrl (output raw, output on_delay, output off_delay,
                  input filtered);
    modport filt (input raw, input on_delay, input off_delay,
                  output filtered);
endinterface

/* File: spo_delay_filter.sv */
/*
 * On/off delay filter for one output pin: the output follows the input
 * only after the input has held still for the whole delay.
 * Assumes delays are given in core_clk cycles by the owner.
 */
module spo_delay_filter #(
    parameter int DW = 16
) (
    input  wire logic core_clk,
    input  wire logic rst,
    spo_filt_if.filt  fi
);
    import spo_pkg::*;

    logic          last_raw;
    logic [DW-1:0] still_cnt;
    logic          out_q;
    logic          next_last_raw;
    logic [DW-1:0] next_still_cnt;
    logic          next_out_q;
    logic [DW-1:0] need;

    always_comb begin
        need           = fi.raw ? fi.on_delay : fi.off_delay;
        next_last_raw  = fi.raw;
        next_still_cnt = still_cnt;
        next_out_q     = out_q;
        if (fi.raw != last_raw) begin
            next_still_cnt = '0;
        end else if (fi.raw != out_q) begin
            if (still_cnt >= need) begin
                next_out_q     = fi.raw;
                next_still_cnt = '0;
            end else begin
                next_still_cnt = still_cnt + 1'b1;
            end
        end else begin
            next_still_cnt = '0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            last_raw  <= 1'b0;
            still_cnt <= '0;
            out_q     <= 1'b0;
        end else begin
            last_raw  <= next_last_raw;
            still_cnt <= next_still_cnt;
            out_q     <= next_out_q;
        end
    end

    assign fi.filtered = out_q;

endmodule // spo_delay_filter

/* File: spo_output_pins.sv */
/*
 * Twelve supply-enable / general-purpose output pins with per-pin function
 * configuration reached by command code and page.
 * Assumes the command port, sequencer, alarm and special-function inputs
 * come from core_clk logic; good/general inputs come from pins.
 * Assumes the host owns channel setup and leaves a pin's setup alone
 * while the supplies it controls are running.
 */
// Functional notes
// - Polarity bit 6: 0 gives active-low pin, 1 gives active-high pin.
// - Drive-type bit 7: 0 gives push-pull, 1 gives open-drain.
// - Code 001 forces pin asserted, code 010 forces pin deasserted.
// - Code 011 asserts when every selected channel good input is high.
// - Code 100 asserts when any enabled channel alarm is active.
// - Mask bit N+16 corresponds to channel N for both combine modes.
// - Alarm feeding the OR is the per-channel chosen alarm function.
// - Code 101 gives fault-two on page 10, sequence pin on page 11.
// - Output changes only after input holds still for the full delay.
module spo_output_pins
    import spo_pkg::*;
#(
    parameter int PINS     = SPO_PINS,
    parameter int CHANNELS = SPO_CHANNELS,
    parameter int DW       = SPO_DELAY_W
) (
    input  wire logic                core_clk,
    input  wire logic                rst,
    input  wire logic [7:0]          cmd_page,
    input  wire logic [7:0]          cmd_code,
    input  wire logic [31:0]         cmd_wdata,
    input  wire logic                cmd_write,
    input  wire logic                cmd_read,
    output logic      [31:0]         cmd_rdata,
    output logic                     cmd_rvalid,
    input  wire logic [PINS-1:0]     supply_enable_req,
    input  wire logic [CHANNELS-1:0] power_good_in,
    input  wire logic [CHANNELS-1:0] channel_alarm,
    input  wire logic                fault_line_two,
    input  wire logic                sequence_pin,
    input  wire logic [DW-1:0]       on_delay,
    input  wire logic [DW-1:0]       off_delay,
    output logic      [PINS-1:0]     supply_enable_output_pin_o,
    output logic      [PINS-1:0]     supply_enable_output_pin_oe
);

    logic [31:0]         pin_cfg      [PINS];
    logic [31:0]         next_pin_cfg [PINS];
    logic [CHANNELS-1:0] good_meta;
    logic [CHANNELS-1:0] good_sync;
    logic [PINS-1:0]     raw_assert;
    logic [PINS-1:0]     filt_assert;
    logic [PINS-1:0]     next_pin_o;
    logic [PINS-1:0]     next_pin_oe;
    logic [31:0]         next_rdata;
    logic                next_rvalid;
    logic                page_ok;
    logic [3:0]          page_idx;
    logic                cfg_wr_hit;
    logic                cfg_rd_hit;
    logic [CHANNELS-1:0] next_good_meta;
    logic [CHANNELS-1:0] next_good_sync;
    logic [2:0]          pin_func     [PINS];
    logic [PINS-1:0]     pin_polarity;
    logic [PINS-1:0]     pin_open_drain;
    logic [PINS-1:0]     and_hit;
    logic [PINS-1:0]     or_hit;
    logic [PINS-1:0]     special_hit;
    logic [PINS-1:0]     pin_level;

    // Pages at or above the pin count address nothing
    assign page_ok  = (cmd_page < 8'(PINS));
    assign page_idx = cmd_page[3:0];
    // Unmapped pages and other codes never touch the store
    assign cfg_wr_hit = cmd_write && cmd_code == CMD_PIN_CFG && page_ok;
    assign cfg_rd_hit = cmd_read && cmd_code == CMD_PIN_CFG && page_ok;

    // Command port: write stores the writable bits, read returns the page
    always_comb begin
        for (int p = 0; p < PINS; p++) begin
            next_pin_cfg[p] = pin_cfg[p];
        end
        next_rdata  = 32'h0000_0000;
        next_rvalid = 1'b0;
        // Write wins over a read in the same cycle
        if (cfg_wr_hit) begin
            next_pin_cfg[page_idx] = cmd_wdata & CFG_RW_MASK;
        end else if (cmd_read && !cmd_write) begin
            // Other codes and pages still answer, with zero
            next_rvalid = 1'b1;
            if (cfg_rd_hit) begin
                next_rdata = pin_cfg[page_idx];
            end
        end
    end

    // Setup words live in flops, one per pin, indexed by page
    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int p = 0; p < PINS; p++) begin
                pin_cfg[p] <= CFG_RESET;
            end
            cmd_rdata  <= 32'h0000_0000;
            cmd_rvalid <= 1'b0;
        end else begin
            for (int p = 0; p < PINS; p++) begin
                pin_cfg[p] <= next_pin_cfg[p];
            end
            cmd_rdata  <= next_rdata;
            cmd_rvalid <= next_rvalid;
        end
    end

    // Good/general inputs arrive from pins: two-stage synchroniser
    always_comb begin
        next_good_meta = power_good_in;
        // Only the second stage reads the first
        next_good_sync = good_meta;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            good_meta <= '0;
            good_sync <= '0;
        end else begin
            good_meta <= next_good_meta;
            good_sync <= next_good_sync;
        end
    end

    // Fields of each pin's setup word
    always_comb begin
        for (int p = 0; p < PINS; p++) begin
            pin_func[p]       = pin_cfg[p][FUNC_MSB:FUNC_LSB];
            pin_polarity[p]   = pin_cfg[p][POLARITY_BIT];
            pin_open_drain[p] = pin_cfg[p][DRIVE_TYPE_BIT];
        end
    end

    // AND/OR and special terms per pin
    always_comb begin
        logic [CHANNELS-1:0] sel;
        sel = '0;
        for (int p = 0; p < PINS; p++) begin
            sel        = pin_cfg[p][MASK_MSB:MASK_LSB];
            // Empty mask asserts: an AND of nothing is true
            and_hit[p] = &(good_sync | ~sel);
            or_hit[p]  = |(channel_alarm & sel);
            if (8'(p) == PAGE_FAULT_TWO) begin
                special_hit[p] = fault_line_two;
            end else if (8'(p) == PAGE_SEQ_PIN) begin
                special_hit[p] = sequence_pin;
            end else begin
                // Special code has no source on the other pages
                special_hit[p] = 1'b0;
            end
        end
    end

    // Per-pin function select, ahead of the delay filter
    always_comb begin
        for (int p = 0; p < PINS; p++) begin
            case (pin_func[p])
                // Sequencer drives the pin; channel setup is the host's part
                FUNC_SUPPLY_EN: raw_assert[p] = supply_enable_req[p];
                // Forced codes ignore every input
                FUNC_FORCE_ON:  raw_assert[p] = 1'b1;
                FUNC_FORCE_OFF: raw_assert[p] = 1'b0;
                FUNC_GOOD_AND:  raw_assert[p] = and_hit[p];
                FUNC_ALARM_OR:  raw_assert[p] = or_hit[p];
                FUNC_SPECIAL:   raw_assert[p] = special_hit[p];
                // Reserved codes fail safe: pin stays deasserted
                default:        raw_assert[p] = 1'b0;
            endcase
        end
    end

    // One filter per pin; the two delays are shared by all pins
    for (genvar g = 0; g < PINS; g++) begin : g_pin
        spo_filt_if #(.DW(DW)) fi ();

        assign fi.raw       = raw_assert[g];
        assign fi.on_delay  = on_delay;
        assign fi.off_delay = off_delay;
        assign filt_assert[g] = fi.filtered;

        spo_delay_filter #(.DW(DW)) u_filt (
            .core_clk (core_clk),
            .rst      (rst),
            .fi       (fi.filt)
        );
    end

    // Polarity first, so the drive stage sees the electrical level
    always_comb begin
        for (int p = 0; p < PINS; p++) begin
            pin_level[p] = filt_assert[p] ~^ pin_polarity[p];
        end
    end

    // Drive per pin
    always_comb begin
        for (int p = 0; p < PINS; p++) begin
            if (pin_open_drain[p]) begin
                // Open drain only pulls low; high comes from the pull-up
                next_pin_o[p]  = 1'b0;
                next_pin_oe[p] = ~pin_level[p];
            end else begin
                next_pin_o[p]  = pin_level[p];
                next_pin_oe[p] = 1'b1;
            end
        end
    end

    // Pins come straight from flops, so a decode change cannot glitch them
    always_ff @(posedge core_clk) begin
        if (rst) begin
            supply_enable_output_pin_o  <= '0;
            supply_enable_output_pin_oe <= '0;
        end else begin
            supply_enable_output_pin_o  <= next_pin_o;
            supply_enable_output_pin_oe <= next_pin_oe;
        end
    end

endmodule // spo_output_pins

/* File: spo_output_pins_chk.sv */
/* Port checker for the supply-enable output pin block.
   Assumes one core_clk domain and synchronous active-high rst. */
module spo_output_pins_chk
    import spo_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic [7:0]  cmd_page,
    input wire logic [7:0]  cmd_code,
    input wire logic [31:0] cmd_wdata,
    input wire logic        cmd_write,
    input wire logic        cmd_read,
    input wire logic [31:0] cmd_rdata,
    input wire logic        cmd_rvalid,
    input wire logic [11:0] supply_enable_output_pin_o,
    input wire logic [11:0] supply_enable_output_pin_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_cfg_write;
        cmd_write && cmd_code == CMD_PIN_CFG && cmd_page < 8'h0C;
    endsequence
    sequence s_same_read;
        cmd_read && !cmd_write && $stable(cmd_page) && cmd_code == CMD_PIN_CFG;
    endsequence
    property p_readback;
        logic [31:0] d;
        (s_cfg_write, d = cmd_wdata) ##1 s_same_read
            |=> cmd_rdata == (d & CFG_RW_MASK);
    endproperty
    chk_read_answered: assert property (cmd_read && !cmd_write |=> cmd_rvalid)
        else $error("read not answered");
    chk_rvalid_cause: assert property (!cmd_read || cmd_write |=> !cmd_rvalid)
        else $error("rvalid without read");
    chk_rdata_idle: assert property (!cmd_rvalid |-> cmd_rdata == 32'h0)
        else $error("rdata not zero when idle");
    chk_rdata_reserved: assert property (
        cmd_rvalid |-> (cmd_rdata & ~CFG_RW_MASK) == 32'h0)
        else $error("reserved bits read nonzero");
    chk_cfg_readback: assert property (p_readback)
        else $error("readback differs");
    chk_od_release: assert property (
        (supply_enable_output_pin_o & ~supply_enable_output_pin_oe) == 12'h0)
        else $error("released pin drives high");
    chk_reset_quiet: assert property (disable iff (1'b0) rst |=>
        supply_enable_output_pin_oe == 12'h0 && !cmd_rvalid)
        else $error("outputs active in reset");
    chk_release_idle: assert property ($fell(rst) |-> ##[1:2]
        (&supply_enable_output_pin_o && &supply_enable_output_pin_oe))
        else $error("pins not deasserted after reset");
endmodule // spo_output_pins_chk

bind spo_output_pins spo_output_pins_chk u_chk (.*);

/* File: spo_pin_load.sv */
/* Load on the twelve pins: pull-ups seen by supplies and LEDs.
   Assumes oe high while the block drives a pin. */
module spo_pin_load
(
    input  wire logic [11:0] pin_o,
    input  wire logic [11:0] pin_oe,
    output logic      [11:0] pin_level
);
    timeunit 1ns;
    timeprecision 1ns;
    // Released open-drain pins float up
    assign pin_level = (pin_o & pin_oe) | ~pin_oe;
endmodule // spo_pin_load

/* File: test_supply_enable_output_config.sv */
/* Self-checking bench for the supply-enable output pin block.
   Assumes the pin load model and the bound port checker. */
module test_supply_enable_output_config
    import spo_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {
        logic [7:0]  pg;
        logic [31:0] cfg;
        logic [15:0] good;
        logic [15:0] alarm;
        logic        o;
        logic        oe;
    } spo_row_s;
    logic        clk, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, rv;
    logic        f2 = 1'b1, sq = 1'b1;
    logic [7:0]  page = 8'h00, code = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [11:0] req = 12'h000, po, poe, lvl;
    logic [15:0] good = 16'h0, alarm = 16'h0;
    logic [15:0] dly_on = 16'h0, dly_off = 16'h0;
    int          errors = 0, checked = 0, cycles = 0;
    spo_row_s    rows [12] = '{
        '{8'h00, 32'h01, 0, 0, 0, 1},
        '{8'h01, 32'h41, 0, 0, 1, 1},
        '{8'h02, 32'hFF3A, 0, 0, 1, 1},
        '{8'h03, 32'hC1, 0, 0, 0, 0},
        '{8'h04, 32'h81, 0, 0, 0, 1},
        '{8'h05, 32'h0005_0043, 5, 0, 1, 1},
        '{8'h06, 32'h0005_0043, 1, 0, 0, 1},
        '{8'h07, 32'h8000_0044, 0, 16'h8000, 1, 1},
        '{8'h08, 32'h8000_0044, 0, 16'h7FFF, 0, 1},
        '{8'h09, 32'h46, 0, 0, 0, 1},
        '{8'h0A, 32'h45, 0, 0, 1, 1},
        '{8'h0B, 32'h45, 0, 0, 1, 1}};
    spo_output_pins u_dut (
        .core_clk(clk), .rst(rst), .cmd_page(page), .cmd_code(code),
        .cmd_wdata(wdata), .cmd_write(wr_s), .cmd_read(rd_s),
        .cmd_rdata(rdata), .cmd_rvalid(rv), .supply_enable_req(req),
        .power_good_in(good), .channel_alarm(alarm), .fault_line_two(f2),
        .sequence_pin(sq), .on_delay(dly_on), .off_delay(dly_off),
        .supply_enable_output_pin_o(po), .supply_enable_output_pin_oe(poe));
    spo_pin_load u_load (.pin_o(po), .pin_oe(poe), .pin_level(lvl));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            print_verdict();
        end
    end
    task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    // Inputs change 10 ns after the edge, never on it
    task automatic step(int n);
        repeat (n) @(posedge clk);
        #10;
    endtask
    task automatic wr(logic [7:0] p, logic [31:0] d);
        page = p;
        code = CMD_PIN_CFG;
        wdata = d;
        wr_s = 1'b1;
        step(1);
        wr_s = 1'b0;
    endtask
    task automatic rd(logic [7:0] p, logic [7:0] c, logic [31:0] e);
        page = p;
        code = c;
        rd_s = 1'b1;
        step(1);
        rd_s = 1'b0;
        cmp("rvalid", 32'h1, {31'h0, rv});
        cmp("rdata", e, rdata);
    endtask
    initial begin
        step(16);
        rst = 1'b0;
        step(3);
        cmp("reset o", 32'hFFF, {20'h0, po});
        cmp("reset oe", 32'hFFF, {20'h0, poe});
        rd(8'h00, CMD_PIN_CFG, CFG_RESET);
        $display("test reset done");
        foreach (rows[i]) begin
            wr(rows[i].pg, rows[i].cfg);
            good = rows[i].good;
            alarm = rows[i].alarm;
            step(10);
            cmp("pin o", {31'h0, rows[i].o}, {31'h0, po[rows[i].pg]});
            cmp("pin oe", {31'h0, rows[i].oe}, {31'h0, poe[rows[i].pg]});
            cmp("level", {31'h0, rows[i].o | ~rows[i].oe},
                {31'h0, lvl[rows[i].pg]});
            rd(rows[i].pg, CMD_PIN_CFG, rows[i].cfg & CFG_RW_MASK);
            $display("test row %0d done", i);
        end
        wr(8'h0C, 32'h41);
        rd(8'h0C, CMD_PIN_CFG, 32'h0);
        step(1);
        rd(8'h01, 8'hD4, 32'h0);
        $display("test unmapped done");
        wr(8'h03, 32'hABCD_12FF);
        rd(8'h03, CMD_PIN_CFG, 32'hABCD_00C7);
        $display("test readback done");
        wr(8'h02, 32'h45);
        step(10);
        cmp("special other", 32'h0, {31'h0, po[2]});
        $display("test special done");
        // Only the on delay is long, so a swapped pair shows up
        dly_on = 16'h0005;
        wr(8'h00, 32'h40);
        step(10);
        req[0] = 1'b1;
        step(3);
        req[0] = 1'b0;
        step(12);
        cmp("glitch", 32'h0, {31'h0, po[0]});
        req[0] = 1'b1;
        step(5);
        cmp("early", 32'h0, {31'h0, po[0]});
        step(6);
        cmp("late", 32'h1, {31'h0, po[0]});
        req[0] = 1'b0;
        step(3);
        cmp("off fast", 32'h0, {31'h0, po[0]});
        $display("test delay done");
        rst = 1'b1;
        step(2);
        cmp("mid reset oe", 32'h0, {20'h0, poe});
        rst = 1'b0;
        step(3);
        cmp("mid release o", 32'hFFF, {20'h0, po});
        cmp("mid release oe", 32'hFFF, {20'h0, poe});
        rd(8'h03, CMD_PIN_CFG, CFG_RESET);
        $display("test mid reset done");
        print_verdict();
    end
endmodule // test_supply_enable_output_config
